//--- logic/rxcce_pkg.sv
// constants and types of the receive-port control-channel error register block
package rxcce_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] ADDR_THOLD = 8'h43;
  localparam logic [7:0] ADDR_RSV44 = 8'h44;
  localparam logic [7:0] ADDR_RSV45 = 8'h45;
  localparam logic [7:0] ADDR_CTL = 8'h46;
  localparam logic [7:0] ADDR_PSEL = 8'h4c;
  localparam logic [7:0] THOLD_RST = 8'h01;
  localparam logic [7:0] CTL_RST = 8'h20;
  localparam logic [7:0] PSEL_RST = 8'h01;
  localparam logic [7:0] RSV_VAL = 8'h00;
  // ********************
  // field positions
  // ********************
  localparam int CTL_ACK_BIT = 7;
  localparam int CTL_CHK_BIT = 6;
  localparam int CTL_ENH_BIT = 5;
  localparam int CTL_FRC_HI = 4;
  localparam int CTL_FRC_LO = 3;
  localparam int CTL_SEL_HI = 2;
  localparam int PSEL_RD_HI = 5;
  localparam int PSEL_RD_LO = 4;
  localparam int PSEL_WR_HI = 3;
  localparam int NPORT = 4;
  // ********************
  // force codes and frame counting
  // ********************
  localparam logic [1:0] FRC_NONE = 2'h0;
  localparam logic [1:0] FRC_CRC_SEL = 2'h1;
  localparam logic [1:0] FRC_CRC_NEXT = 2'h2;
  localparam logic [1:0] FRC_DATA_SEL = 2'h3;
  localparam logic [3:0] FRAME_LIMIT = 4'h8;
  localparam logic [3:0] FRAME_ONE = 4'h1;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // register request from the i2c slave front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rxcce_req_t;
  // injection state, one-hot
  typedef enum logic [2:0] {
    INJ_IDLE = 3'h1,
    INJ_ARMED = 3'h2,
    INJ_WAIT_NORMAL = 3'h4
  } rxcce_inj_t;
endpackage

//--- logic/rxcce_regs.sv
// register bank and per-port control-channel error control
`timescale 1ns/1ps
module rxcce_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access from the i2c slave
  input rxcce_pkg::rxcce_req_t reg_req,
  output logic [7:0] reg_rdata,
  // adaptive equalizer, per port
  input wire logic [3:0] adapt_active,
  input wire logic [3:0] adapt_err,
  output logic [3:0] eq_step_up,
  // remote i2c transactions, per port
  input wire logic [3:0] remote_read_start,
  output logic [3:0] remote_read_ack,
  input wire logic [3:0] ack_valid,
  input wire logic [3:0] remote_nack,
  input wire logic [3:0][7:0] data_sent,
  input wire logic [3:0][7:0] data_returned,
  output logic [3:0] local_nack,
  // channel error sources, per port
  input wire logic [3:0] chan_err,
  input wire logic [3:0] master_active,
  input wire logic [3:0] slave_active,
  output logic [3:0] xact_terminate,
  output logic [3:0] master_err,
  output logic [3:0] slave_err,
  // forward channel framing and injection, per port
  input wire logic [3:0] fwd_byte,
  input wire logic [3:0] fwd_block_first,
  input wire logic [3:0] normal_frame,
  output logic [3:0] inject_crc,
  output logic [3:0] inject_data
);
  // ********************
  // register state
  // ********************
  logic [7:0] thold_reg, thold_next;
  logic [7:0] psel_reg, psel_next;
  logic [3:0][7:0] ctl_reg, ctl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] rd_port;
  logic [3:0] ctl_wr;
  assign rd_port = psel_reg[rxcce_pkg::PSEL_RD_HI:rxcce_pkg::PSEL_RD_LO];
  assign reg_rdata = rdata_reg;

  // decode and readback; unmapped and reserved offsets read zero
  always_comb
  begin
    thold_next = thold_reg;
    psel_next = psel_reg;
    ctl_next = ctl_reg;
    rdata_next = rdata_reg;
    ctl_wr = 4'h0;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        rxcce_pkg::ADDR_THOLD: thold_next = reg_req.wdata;
        rxcce_pkg::ADDR_PSEL: psel_next = reg_req.wdata;
        rxcce_pkg::ADDR_CTL:
        begin
          for (int p = 0; p < rxcce_pkg::NPORT; p++)
          begin
            if (psel_reg[p])
            begin
              ctl_next[p] = reg_req.wdata;
              ctl_wr[p] = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        rxcce_pkg::ADDR_THOLD: rdata_next = thold_reg;
        rxcce_pkg::ADDR_PSEL: rdata_next = psel_reg;
        rxcce_pkg::ADDR_CTL: rdata_next = ctl_reg[rd_port];
        default: rdata_next = rxcce_pkg::RSV_VAL;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thold_reg <= rxcce_pkg::THOLD_RST;
      psel_reg <= rxcce_pkg::PSEL_RST;
      ctl_reg <= {rxcce_pkg::NPORT{rxcce_pkg::CTL_RST}};
      rdata_reg <= rxcce_pkg::RSV_VAL;
    end
    else
    begin
      thold_reg <= thold_next;
      psel_reg <= psel_next;
      ctl_reg <= ctl_next;
      rdata_reg <= rdata_next;
    end
  end

  // ********************
  // per-port transaction checks
  // ********************
  logic [3:0][7:0] cnt_reg, cnt_next;
  logic [3:0] step_reg, step_next;
  logic [3:0] rrack_reg, rrack_next;
  logic [3:0] nack_reg, nack_next;
  logic [3:0] term_reg, term_next;
  logic [3:0] merr_reg, merr_next;
  logic [3:0] serr_reg, serr_next;
  assign eq_step_up = step_reg;
  assign remote_read_ack = rrack_reg;
  assign local_nack = nack_reg;
  assign xact_terminate = term_reg;
  assign master_err = merr_reg;
  assign slave_err = serr_reg;

  // error count saturates at CNT_MAX instead of wrapping back to zero
  always_comb
  begin
    logic [7:0] inc;
    inc = rxcce_pkg::CNT_ONE;
    cnt_next = cnt_reg;
    step_next = 4'h0;
    rrack_next = 4'h0;
    nack_next = 4'h0;
    term_next = 4'h0;
    merr_next = 4'h0;
    serr_next = 4'h0;
    for (int p = 0; p < rxcce_pkg::NPORT; p++)
    begin
      inc = (cnt_reg[p] == rxcce_pkg::CNT_MAX) ? cnt_reg[p] : cnt_reg[p] + rxcce_pkg::CNT_ONE;
      if (!adapt_active[p])
        cnt_next[p] = 8'h00;
      else if (adapt_err[p])
      begin
        if (inc > thold_reg)
        begin
          step_next[p] = 1'b1;
          cnt_next[p] = 8'h00;
        end
        else
          cnt_next[p] = inc;
      end
      rrack_next[p] = remote_read_start[p] & ctl_reg[p][rxcce_pkg::CTL_ACK_BIT];
      if (ack_valid[p])
        nack_next[p] = remote_nack[p] |
          (ctl_reg[p][rxcce_pkg::CTL_CHK_BIT] & (data_sent[p] != data_returned[p]));
      if (chan_err[p] & ctl_reg[p][rxcce_pkg::CTL_ENH_BIT])
      begin
        term_next[p] = master_active[p] | slave_active[p];
        merr_next[p] = master_active[p];
        serr_next[p] = slave_active[p];
      end
    end
  end

  // transaction check flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      step_reg <= 4'h0;
      rrack_reg <= 4'h0;
      nack_reg <= 4'h0;
      term_reg <= 4'h0;
      merr_reg <= 4'h0;
      serr_reg <= 4'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      rrack_reg <= rrack_next;
      nack_reg <= nack_next;
      term_reg <= term_next;
      merr_reg <= merr_next;
      serr_reg <= serr_next;
    end
  end

  // ********************
  // one-shot error injection
  // ********************
  rxcce_pkg::rxcce_inj_t [3:0] inj_reg, inj_next;
  logic [3:0][3:0] idx_reg, idx_next;
  logic [3:0] icrc_reg, icrc_next;
  logic [3:0] idat_reg, idat_next;
  assign inject_crc = icrc_reg;
  assign inject_data = idat_reg;

  // a fresh write re-arms; the field keeps its value but fires only once
  always_comb
  begin
    logic [3:0] cur;
    logic [1:0] frc;
    cur = 4'h0;
    frc = rxcce_pkg::FRC_NONE;
    inj_next = inj_reg;
    idx_next = idx_reg;
    icrc_next = 4'h0;
    idat_next = 4'h0;
    for (int p = 0; p < rxcce_pkg::NPORT; p++)
    begin
      frc = ctl_reg[p][rxcce_pkg::CTL_FRC_HI:rxcce_pkg::CTL_FRC_LO];
      cur = fwd_block_first[p] ? 4'h0 : idx_reg[p];
      if (fwd_byte[p] && cur < rxcce_pkg::FRAME_LIMIT)
        idx_next[p] = cur + rxcce_pkg::FRAME_ONE;
      case (inj_reg[p])
        rxcce_pkg::INJ_IDLE: ;
        rxcce_pkg::INJ_ARMED:
        begin
          if (fwd_byte[p] && cur == {1'b0, ctl_reg[p][rxcce_pkg::CTL_SEL_HI:0]})
          begin
            inj_next[p] = rxcce_pkg::INJ_IDLE;
            case (frc)
              rxcce_pkg::FRC_CRC_SEL: icrc_next[p] = 1'b1;
              rxcce_pkg::FRC_DATA_SEL: idat_next[p] = 1'b1;
              rxcce_pkg::FRC_CRC_NEXT: inj_next[p] = rxcce_pkg::INJ_WAIT_NORMAL;
              default: ;
            endcase
          end
        end
        rxcce_pkg::INJ_WAIT_NORMAL:
        begin
          if (normal_frame[p])
          begin
            icrc_next[p] = 1'b1;
            inj_next[p] = rxcce_pkg::INJ_IDLE;
          end
        end
        default: inj_next[p] = rxcce_pkg::INJ_IDLE;
      endcase
      if (ctl_wr[p])
        inj_next[p] = (reg_req.wdata[rxcce_pkg::CTL_FRC_HI:rxcce_pkg::CTL_FRC_LO] != rxcce_pkg::FRC_NONE) ?
          rxcce_pkg::INJ_ARMED : rxcce_pkg::INJ_IDLE;
    end
  end

  // injection flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inj_reg <= '{default: rxcce_pkg::INJ_IDLE};
      idx_reg <= '0;
      icrc_reg <= 4'h0;
      idat_reg <= 4'h0;
    end
    else
    begin
      inj_reg <= inj_next;
      idx_reg <= idx_next;
      icrc_reg <= icrc_next;
      idat_reg <= idat_next;
    end
  end

  // ********************
  // checks on port 0, plus the threshold reset value and the banked read of the rd_port port
  // ********************
  a_thold_reset: assert property (@(posedge sys_clk) $rose(rst_n) |-> thold_reg == rxcce_pkg::THOLD_RST)
    else $error("threshold not one after reset");
  a_step_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eq_step_up[0] |-> $past(adapt_active[0] && adapt_err[0] && thold_reg <= cnt_reg[0]))
    else $error("step up without threshold crossing");
  a_read_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == rxcce_pkg::ADDR_CTL |=> reg_rdata == $past(ctl_reg[rd_port]))
    else $error("banked read from wrong port");
  a_write_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == rxcce_pkg::ADDR_CTL && !psel_reg[0] |=> $stable(ctl_reg[0]))
    else $error("write reached disabled port");
  a_rr_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    remote_read_start[0] && ctl_reg[0][rxcce_pkg::CTL_ACK_BIT] |=> remote_read_ack[0])
    else $error("remote read not acknowledged");
  a_data_nack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_valid[0] && ctl_reg[0][rxcce_pkg::CTL_CHK_BIT] && data_sent[0] != data_returned[0] |=> local_nack[0])
    else $error("mismatch not turned into nack");
  a_enh_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (master_err[0] || slave_err[0] || xact_terminate[0]) |-> $past(ctl_reg[0][rxcce_pkg::CTL_ENH_BIT]))
    else $error("error reported with enhanced checking off");
  a_one_shot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inject_crc[0] || inject_data[0]) && !$past(ctl_wr[0]) |=> !(inject_crc[0] || inject_data[0]))
    else $error("injection repeated");
  a_data_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    inject_data[0] |-> $past(ctl_reg[0][rxcce_pkg::CTL_FRC_HI:rxcce_pkg::CTL_FRC_LO]) == rxcce_pkg::FRC_DATA_SEL)
    else $error("data error under wrong code");
  c_step: cover property (@(posedge sys_clk) disable iff (!rst_n) eq_step_up[0]);
  c_nack: cover property (@(posedge sys_clk) disable iff (!rst_n) local_nack[0] && !$past(remote_nack[0]));
  c_crc_next: cover property (@(posedge sys_clk) disable iff (!rst_n)
    inj_reg[0] == rxcce_pkg::INJ_WAIT_NORMAL ##[1:20] inject_crc[0]);
endmodule // rxcce_regs

//--- dv/rxcce_ser_model.sv
// behavioural serializer that answers the ack cycles of remote writes
`timescale 1ns/1ps
module rxcce_ser_model (
  // ack cycle and data written
  input wire logic [3:0] ack_valid,
  input wire logic [3:0][7:0] data_sent,
  // bad return per port, commanded by the bench
  input wire logic [3:0] corrupt,
  // data echoed back
  output logic [3:0][7:0] data_returned
);
  // echo during the ack; outside it the lines show the inverse, never a stale copy
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      data_returned[p] = ack_valid[p] ? (data_sent[p] ^ {7'h00, corrupt[p]}) : ~data_sent[p];
    end
  end
endmodule // rxcce_ser_model

//--- dv/rx_port_control_channel_error_ctl_tb_top.sv
// self-checking bench of the receive-port control-channel error registers
`timescale 1ns/1ps
module rx_port_control_channel_error_ctl_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  rxcce_pkg::rxcce_req_t req = '0;
  logic [7:0] reg_rdata;
  // event inputs: adapt_err, read start, ack, chan_err, fwd byte, block first, normal frame
  logic [27:0] evs = '0;
  logic [3:0] corrupt = 4'h0;
  // level inputs: adaptation window, remote nack, active master and slave
  logic [3:0] adapt_on = 4'hf;
  logic [3:0] r_nack = 4'h0;
  logic [3:0] m_act = 4'hf;
  logic [3:0] s_act = 4'h0;
  logic [3:0][7:0] ds = '0;
  logic [3:0][7:0] dr;
  wire logic [31:0] outs;
  logic [31:0] pq[$];
  logic [7:0] rq[$];
  logic pend = 1'b0;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 34;
  int thr;
  int sel;
  // ********************
  // design and far side
  // ********************
  rxcce_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(reg_rdata),
    .adapt_active(adapt_on), .adapt_err(evs[27:24]), .eq_step_up(outs[31:28]),
    .remote_read_start(evs[23:20]), .remote_read_ack(outs[27:24]), .ack_valid(evs[19:16]),
    .remote_nack(r_nack), .data_sent(ds), .data_returned(dr), .local_nack(outs[23:20]),
    .chan_err(evs[15:12]), .master_active(m_act), .slave_active(s_act), .xact_terminate(outs[19:16]),
    .master_err(outs[15:12]), .slave_err(outs[11:8]), .fwd_byte(evs[11:8]),
    .fwd_block_first(evs[7:4]), .normal_frame(evs[3:0]), .inject_crc(outs[7:4]), .inject_data(outs[3:0]));
  rxcce_ser_model i_ser (.ack_valid(evs[19:16]), .data_sent(ds), .corrupt(corrupt), .data_returned(dr));
  // clock at 100 ns
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  // ********************
  // shared tasks
  // ********************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register strobe; for a read d is the expected byte
  task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: wr, rd: ~wr};
    if (!wr) rq.push_back(d);
    @(posedge sys_clk);
    req <= '0;
  endtask
  // one cycle of event pulses and the output word it should cause
  task ev(input logic [27:0] v, input logic [31:0] e);
    @(posedge sys_clk);
    evs <= v;
    if (e != 32'h0) pq.push_back(e);
    @(posedge sys_clk);
    evs <= '0;
  endtask
  task end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watcher: any output pulse takes the oldest note, read data one cycle after rd
  always @(negedge sys_clk)
  begin
    if (outs !== 32'h0) chk(outs, (pq.size() == 0) ? 32'h0 : pq.pop_front());
    if (pend) chk({24'h0, reg_rdata}, {24'h0, rq.pop_front()});
    pend = req.rd;
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #3000000;
    n_errors++;
    end_sim();
  end
  // ********************
  // scenarios
  // ********************
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    ds <= $random(seed);
    // reset values, reserved and unmapped places
    acc(0, 8'h43, 8'h01);
    acc(1, 8'h44, 8'h5a);
    acc(0, 8'h44, 8'h00);
    acc(0, 8'h45, 8'h00);
    acc(0, 8'h50, 8'h00);
    acc(0, 8'h46, 8'h20);
    acc(0, 8'h4c, 8'h01);
    // one write reaching two ports, then a distinct value per port
    acc(1, 8'h4c, 8'h05);
    acc(1, 8'h46, 8'h24);
    // read select walks the ports, write enables stay on ports 0 and 2
    for (int p = 0; p < 4; p++)
    begin
      acc(1, 8'h4c, {2'h0, p[1:0], 4'h5});
      acc(0, 8'h46, (p % 2 == 0) ? 8'h24 : 8'h20);
    end
    for (int p = 0; p < 4; p++)
    begin
      acc(1, 8'h4c, 8'h01 << p);
      acc(1, 8'h46, 8'h20 | p[7:0]);
    end
    for (int p = 0; p < 4; p++)
    begin
      acc(1, 8'h4c, {2'h0, p[1:0], 4'h0});
      acc(0, 8'h46, 8'h20 | p[7:0]);
    end
    // threshold: step up on the error that passes it, never a zero threshold
    thr = 2 + ($random(seed) & 3);
    acc(1, 8'h43, thr[7:0]);
    for (int i = 0; i < thr; i++) ev({4'h1, 24'h0}, 32'h0);
    // closing the adaptation window must forget the errors seen so far
    adapt_on <= 4'he;
    @(posedge sys_clk);
    adapt_on <= 4'hf;
    for (int i = 0; i <= thr; i++) ev({4'h1, 24'h0}, (i == thr) ? 32'h1000_0000 : 32'h0);
    // partner supports enhanced checking, so ack and data check may be set on port 1
    acc(1, 8'h4c, 8'h02);
    acc(1, 8'h46, 8'ha0);
    ev({4'h0, 4'hf, 20'h0}, {4'h0, 4'h2, 24'h0});
    acc(1, 8'h46, 8'he0);
    corrupt <= 4'h3;
    ev({8'h0, 4'hf, 16'h0}, {8'h0, 4'h2, 20'h0});
    corrupt <= 4'h0;
    ev({8'h0, 4'h2, 16'h0}, 32'h0);
    // a nack from the far side passes through even with data check off
    r_nack <= 4'h1;
    ev({8'h0, 4'h1, 16'h0}, {8'h0, 4'h1, 20'h0});
    r_nack <= 4'h0;
    // channel errors ignored on port 2 with enhanced checking off
    acc(1, 8'h4c, 8'h04);
    acc(1, 8'h46, 8'h00);
    ev({12'h0, 4'h7, 12'h0}, {12'h0, 4'h3, 4'h3, 12'h0});
    // slave side active on port 0: terminate and slave error only
    m_act <= 4'h0;
    s_act <= 4'h1;
    ev({12'h0, 4'h1, 12'h0}, {12'h0, 4'h1, 4'h0, 4'h1, 8'h0});
    m_act <= 4'hf;
    s_act <= 4'h0;
    // every force code on port 3, two blocks each, the second must stay clean
    acc(1, 8'h4c, 8'h08);
    for (int c = 0; c < 4; c++)
    begin
      sel = $random(seed) & 7;
      acc(1, 8'h46, {3'h1, c[1:0], sel[2:0]});
      for (int b = 0; b < 2; b++)
      begin
        for (int k = 0; k < 8; k++)
          ev({16'h0, 4'h8, (k == 0) ? 4'h8 : 4'h0, 4'h0},
            (b == 0 && k == sel && c[0]) ? ((c == 3) ? 32'h08 : 32'h80) : 32'h0);
        ev(28'h8, (b == 0 && c == 2) ? 32'h80 : 32'h0);
      end
    end
    repeat (3) @(posedge sys_clk);
    chk(32'(pq.size()), 32'h0);
    end_sim();
  end
endmodule // rx_port_control_channel_error_ctl_tb_top
